// ===== hdl/sacs_pkg.sv
// Package: constants and types for the sampling converter sequencer
package sacs_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned HOLD_NS = 120;
  localparam int unsigned COARSE_NS = 220;
  localparam int unsigned RESULT_NS = 330;
  localparam int unsigned PD_SAMPLE_NS = 530;
  localparam int unsigned PWRUP_EXT_NS = 1000;
  localparam int unsigned PWRUP_INT_NS = 25000;
  // Least times round up to whole cycles
  localparam int unsigned HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned COARSE_CYC = (COARSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESULT_CYC = (RESULT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PD_SAMPLE_CYC = (PD_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PWRUP_EXT_CYC = (PWRUP_EXT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PWRUP_INT_CYC = (PWRUP_INT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RES_W = 8;
  localparam int unsigned NIB_W = 4;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned BIT_CNT_W = 4;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 4'h7;
  localparam logic [BIT_CNT_W-1:0] FRAME_END = 4'h8;

  typedef enum {
    SACS_DOWN,
    SACS_WAKE,
    SACS_READY,
    SACS_HOLD,
    SACS_CONV
  } sacs_state_t;

  typedef struct packed {
    logic data;
    logic data_oe;
    logic frame_marker;
  } sacs_serial_t;
endpackage : sacs_pkg

// ===== hdl/sacs_sequencer.sv
// Conversion sequencer: power control, track/hold timing, two-step result, serial frame
// Notes on behaviour
// R01: Track resumes 120 ns after trigger fall
// R02: Host waits acquisition time before next start
// R03: Coarse upper nibble, then fine lower nibble
// R04: Finished result loads serial shift register
// R05: Hold input 120 ns after conversion start
// R06: Coarse at 220 ns, result at 330
// R07: Acquisition overlaps ongoing conversion
// R08: Frame marker idles high; trigger fall starts conversion
// R09: First shift rise after end: marker low
// R10: Host supplies free-running shift clock
// R11: Result is straight unsigned binary
// R12: Starts powered down, no conversion yet
// R13: Trigger rise powers the device up
// R14: Power-up 1 us external, 25 us internal
// R15: Early fall deferred until power-up done
// R16: Fall after power-up starts at once
// R17: Host waits 25 us with internal reference
// R18: MSB first on rising edges, eight bits
// R19: Release data after eighth shift falling edge
// R20: Marker high on ninth rise or trigger
// R21: Sample trigger at 530 ns; low powers down
// R22: Trigger high there keeps device powered
// R23: Result taken from sample input at start
module sacs_sequencer
  import sacs_pkg::*;
#(
  parameter int unsigned PWRUP_EXT_CYCLES = PWRUP_EXT_CYC,
  parameter int unsigned PWRUP_INT_CYCLES = PWRUP_INT_CYC
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic conversion_trigger_n_i,
  input wire logic shift_clock_i,
  input wire logic use_internal_ref_i,
  input wire logic [RES_W-1:0] analog_sample_i,
  output logic frame_marker_o,
  output logic serial_result_o,
  output logic serial_result_oe_o,
  output logic powered_up_o,
  output logic track_mode_o,
  output logic converting_o,
  output logic [RES_W-1:0] result_o
);

  initial begin
    if (PWRUP_EXT_CYCLES < 1 || PWRUP_INT_CYCLES < 1 || PWRUP_EXT_CYCLES >= (1 << CNT_W) ||
        PWRUP_INT_CYCLES >= (1 << CNT_W)) begin
      $error("sacs_sequencer: power-up counts out of range");
    end
    // Phase points share one counter, so they must follow one another
    if (HOLD_CYC >= COARSE_CYC || COARSE_CYC >= RESULT_CYC || RESULT_CYC >= PD_SAMPLE_CYC ||
        PD_SAMPLE_CYC >= (1 << CNT_W)) begin
      $error("sacs_sequencer: conversion phase points out of order");
    end
  end

  // Pin synchronisers: three stages, change taken when stages two and three agree
  // Reset levels equal the idle pin levels, so no false edge follows reset
  logic [2:0] trig_sync_r;
  logic [2:0] trig_sync_nxt;
  logic [2:0] sclk_sync_r;
  logic [2:0] sclk_sync_nxt;
  logic trig_lvl_r;
  logic trig_lvl_nxt;
  logic sclk_lvl_r;
  logic sclk_lvl_nxt;
  logic trig_fall;
  logic trig_rise;
  logic sclk_rise;
  logic sclk_fall;

  always_comb begin
    trig_sync_nxt = {trig_sync_r[1:0], conversion_trigger_n_i};
    sclk_sync_nxt = {sclk_sync_r[1:0], shift_clock_i};
    trig_lvl_nxt = trig_lvl_r;
    sclk_lvl_nxt = sclk_lvl_r;
    if (trig_sync_r[1] == trig_sync_r[2]) begin
      trig_lvl_nxt = trig_sync_r[2];
    end
    if (sclk_sync_r[1] == sclk_sync_r[2]) begin
      sclk_lvl_nxt = sclk_sync_r[2];
    end
  end

  assign trig_fall = trig_lvl_r & ~trig_lvl_nxt;
  assign trig_rise = ~trig_lvl_r & trig_lvl_nxt;
  assign sclk_rise = ~sclk_lvl_r & sclk_lvl_nxt;
  assign sclk_fall = sclk_lvl_r & ~sclk_lvl_nxt;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      trig_sync_r <= 3'h7;
      sclk_sync_r <= 3'h0;
      trig_lvl_r <= 1'b1;
      sclk_lvl_r <= 1'b0;
    end else begin
      trig_sync_r <= trig_sync_nxt;
      sclk_sync_r <= sclk_sync_nxt;
      trig_lvl_r <= trig_lvl_nxt;
      sclk_lvl_r <= sclk_lvl_nxt;
    end
  end

  // Power and conversion sequencing
  sacs_state_t state_r;
  sacs_state_t state_nxt;
  logic [CNT_W-1:0] pwr_cnt_r;
  logic [CNT_W-1:0] pwr_cnt_nxt;
  logic [CNT_W-1:0] conv_cnt_r;
  logic [CNT_W-1:0] conv_cnt_nxt;
  logic pending_r;
  logic pending_nxt;
  logic pd_check_r;
  logic pd_check_nxt;
  logic track_r;
  logic track_nxt;
  logic [RES_W-1:0] sample_r;
  logic [RES_W-1:0] sample_nxt;
  logic [RES_W-1:0] result_r;
  logic [RES_W-1:0] result_nxt;
  logic eoc;
  logic start;
  logic [CNT_W-1:0] pwr_target;

  // Reference choice only matters while waking; keep it static meanwhile
  assign pwr_target = use_internal_ref_i ? CNT_W'(PWRUP_INT_CYCLES) : CNT_W'(PWRUP_EXT_CYCLES);

  always_comb begin
    state_nxt = state_r;
    pwr_cnt_nxt = pwr_cnt_r;
    conv_cnt_nxt = conv_cnt_r;
    pending_nxt = pending_r;
    pd_check_nxt = pd_check_r;
    track_nxt = track_r;
    sample_nxt = sample_r;
    result_nxt = result_r;
    eoc = 1'b0;
    start = 1'b0;
    unique case (state_r)
      SACS_DOWN: begin
        // Stays in low current until the trigger rises [R12]
        if (trig_rise) begin
          state_nxt = SACS_WAKE; // [R13]
          pwr_cnt_nxt = '0;
          pending_nxt = 1'b0;
        end
      end
      SACS_WAKE: begin
        pwr_cnt_nxt = pwr_cnt_r + CNT_W'(1);
        // An early fall is remembered and served once powered [R15]
        if (trig_fall) begin
          pending_nxt = 1'b1;
        end
        if (pwr_cnt_r + CNT_W'(1) >= pwr_target) begin // [R14]
          if (pending_r | trig_fall) begin
            start = 1'b1;
          end else begin
            state_nxt = SACS_READY;
          end
        end
      end
      SACS_READY: begin
        if (trig_fall) begin
          start = 1'b1; // [R08] [R16]
        end
      end
      SACS_HOLD, SACS_CONV: begin
        conv_cnt_nxt = conv_cnt_r + CNT_W'(1);
        if (conv_cnt_r + CNT_W'(1) == CNT_W'(HOLD_CYC)) begin
          track_nxt = 1'b1; // [R01] [R07]
          state_nxt = SACS_CONV;
        end
        // Coarse nibble first, fine nibble after, unsigned code [R03] [R11]
        if (conv_cnt_r + CNT_W'(1) == CNT_W'(COARSE_CYC)) begin
          result_nxt[RES_W-1:NIB_W] = sample_r[RES_W-1:NIB_W];
        end
        if (conv_cnt_r + CNT_W'(1) == CNT_W'(RESULT_CYC)) begin
          result_nxt[NIB_W-1:0] = sample_r[NIB_W-1:0]; // [R06]
          eoc = 1'b1;
        end
        // Power-down decision at the 530 ns sample point [R21] [R22]
        if (conv_cnt_r + CNT_W'(1) == CNT_W'(PD_SAMPLE_CYC)) begin
          pd_check_nxt = 1'b0;
          state_nxt = trig_lvl_r ? SACS_READY : SACS_DOWN;
        end
      end
      default: state_nxt = SACS_DOWN;
    endcase
    if (start) begin
      state_nxt = SACS_HOLD;
      conv_cnt_nxt = '0;
      pending_nxt = 1'b0;
      pd_check_nxt = 1'b1;
      track_nxt = 1'b0; // [R05]
      sample_nxt = analog_sample_i; // [R23]
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_r <= SACS_DOWN;
      pwr_cnt_r <= '0;
      conv_cnt_r <= '0;
      pending_r <= 1'b0;
      pd_check_r <= 1'b0;
      track_r <= 1'b1;
      sample_r <= '0;
      result_r <= '0;
    end else begin
      state_r <= state_nxt;
      pwr_cnt_r <= pwr_cnt_nxt;
      conv_cnt_r <= conv_cnt_nxt;
      pending_r <= pending_nxt;
      pd_check_r <= pd_check_nxt;
      track_r <= track_nxt;
      sample_r <= sample_nxt;
      result_r <= result_nxt;
    end
  end

  // Serial side; shift clock must run continuously for framing to follow [R10]
  logic [RES_W-1:0] shreg_r;
  logic [RES_W-1:0] shreg_nxt;
  logic loaded_r;
  logic loaded_nxt;
  logic active_r;
  logic active_nxt;
  logic [BIT_CNT_W-1:0] bit_cnt_r;
  logic [BIT_CNT_W-1:0] bit_cnt_nxt;
  sacs_serial_t ser_r;
  sacs_serial_t ser_nxt;

  always_comb begin
    shreg_nxt = shreg_r;
    loaded_nxt = loaded_r;
    active_nxt = active_r;
    bit_cnt_nxt = bit_cnt_r;
    ser_nxt = ser_r;
    if (sclk_rise && active_r) begin
      if (bit_cnt_r < LAST_BIT) begin
        ser_nxt.data = shreg_r[RES_W-1];
        shreg_nxt = {shreg_r[RES_W-2:0], 1'b0}; // [R18]
        bit_cnt_nxt = bit_cnt_r + BIT_CNT_W'(1);
      end else begin
        // Ninth rise closes the frame
        ser_nxt.frame_marker = 1'b1; // [R20]
        ser_nxt.data_oe = 1'b0;
        active_nxt = 1'b0;
        bit_cnt_nxt = FRAME_END;
      end
    end else if (sclk_rise && loaded_r) begin
      loaded_nxt = 1'b0;
      active_nxt = 1'b1;
      ser_nxt.frame_marker = 1'b0; // [R09]
      ser_nxt.data_oe = 1'b1;
      ser_nxt.data = shreg_r[RES_W-1]; // [R18]
      shreg_nxt = {shreg_r[RES_W-2:0], 1'b0};
      bit_cnt_nxt = '0;
    end
    if (sclk_fall && active_r && bit_cnt_r == LAST_BIT) begin
      ser_nxt.data_oe = 1'b0; // [R19]
    end
    // Without a ninth rise the frame stays open until the next trigger fall
    if (trig_fall && active_r) begin
      ser_nxt.frame_marker = 1'b1; // [R20]
      ser_nxt.data_oe = 1'b0;
      active_nxt = 1'b0;
    end
    if (eoc) begin
      shreg_nxt = {result_r[RES_W-1:NIB_W], sample_r[NIB_W-1:0]}; // [R04]
      loaded_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      shreg_r <= '0;
      loaded_r <= 1'b0;
      active_r <= 1'b0;
      bit_cnt_r <= '0;
      ser_r <= '{data: 1'b0, data_oe: 1'b0, frame_marker: 1'b1};
    end else begin
      shreg_r <= shreg_nxt;
      loaded_r <= loaded_nxt;
      active_r <= active_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      ser_r <= ser_nxt;
    end
  end

  // Start of a new conversion while a read is still running is the host's concern [R02] [R17]
  assign frame_marker_o = ser_r.frame_marker;
  assign serial_result_o = ser_r.data;
  assign serial_result_oe_o = ser_r.data_oe;
  assign powered_up_o = (state_r != SACS_DOWN);
  assign track_mode_o = track_r;
  assign converting_o = pd_check_r;
  assign result_o = result_r;

endmodule : sacs_sequencer

// ===== tb/sacs_sequencer_checker.sv
// Checker: timing relations at the sequencer pins
module sacs_sequencer_checker
  import sacs_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic conversion_trigger_n_i,
  input wire logic [RES_W-1:0] analog_sample_i,
  input wire logic frame_marker_o,
  input wire logic serial_result_oe_o,
  input wire logic powered_up_o,
  input wire logic track_mode_o,
  input wire logic converting_o,
  input wire logic [RES_W-1:0] result_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  a_track_resume: assert property ($rose(converting_o) |-> !track_mode_o ##6 track_mode_o)
    else $error("track mode not resumed after hold");
  a_conv_span: assert property ($rose(converting_o) |-> ##25 converting_o ##[1:2] !converting_o)
    else $error("conversion span wrong");
  a_coarse_nibble: assert property ($rose(converting_o) |-> ##11
    result_o[RES_W-1:NIB_W] == $past(analog_sample_i[RES_W-1:NIB_W], 12))
    else $error("coarse nibble wrong");
  a_fine_result: assert property ($rose(converting_o) |-> ##17
    result_o == $past(analog_sample_i, 18))
    else $error("result wrong at fine point");
  a_down_no_start: assert property ($rose(converting_o) |-> $past(powered_up_o))
    else $error("conversion started while down");
  a_power_choice: assert property ($fell(converting_o) |-> powered_up_o == $past(conversion_trigger_n_i, 5))
    else $error("power decision wrong");
  a_frame_opens: assert property ($fell(frame_marker_o) |-> serial_result_oe_o)
    else $error("frame opened without data drive");
  a_oe_in_frame: assert property (serial_result_oe_o |-> !frame_marker_o)
    else $error("data driven outside frame");
  c_mode_two: cover property ($fell(powered_up_o));
  c_mode_one: cover property ($fell(converting_o) && powered_up_o);
  c_frame: cover property ($fell(frame_marker_o));
endmodule : sacs_sequencer_checker
bind sacs_sequencer sacs_sequencer_checker chk_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .conversion_trigger_n_i(conversion_trigger_n_i), .analog_sample_i(analog_sample_i),
  .frame_marker_o(frame_marker_o), .serial_result_oe_o(serial_result_oe_o), .powered_up_o(powered_up_o),
  .track_mode_o(track_mode_o), .converting_o(converting_o), .result_o(result_o));

// ===== tb/sacs_serial_rx.sv
// Partner: serial receive port with a free-running shift clock
module sacs_serial_rx
  import sacs_pkg::*;
(
  input wire logic frame_marker_i,
  input wire logic data_i,
  input wire logic oe_i,
  output logic shift_clock_o,
  output logic [RES_W-1:0] word_o,
  output int bits_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    shift_clock_o = 1'b0;
    word_o = '0;
    bits_o = 0;
    #87;
    // Clock never stops, frames or not
    forever begin
      shift_clock_o = 1'b1;
      #80 shift_clock_o = 1'b0;
      // Late sample: the pin reaches the data only after its synchroniser
      #40 if (oe_i && !frame_marker_i) begin
        word_o = {word_o[RES_W-2:0], data_i};
        bits_o++;
      end
      #40;
    end
  end
endmodule : sacs_serial_rx

// ===== tb/tb_sacs_sequencer.sv
// Testbench: conversion sequencer against a serial receiver
module tb_sacs_sequencer
  import sacs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic trig_n = 1'b1;
  logic use_int = 1'b0;
  logic [RES_W-1:0] sample = '0;
  logic frame_marker_o, serial_result_o, serial_result_oe_o, powered_up_o, track_mode_o, converting_o;
  logic [RES_W-1:0] result_o, rx_word;
  logic shift_clk, data_line;
  int num_errors = 0, total_checks = 0, rx_bits, n_wait, n_start, rx_mark;
  logic [15:0] rows [4] = '{16'h0000, 16'hffff, 16'ha5a5, 16'h3c3c};
  // Released line shows the inverse so a stale bit cannot pass
  assign data_line = serial_result_oe_o ? serial_result_o : !serial_result_o;
  sacs_sequencer #(.PWRUP_EXT_CYCLES(40), .PWRUP_INT_CYCLES(60)) uut (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .conversion_trigger_n_i(trig_n), .shift_clock_i(shift_clk), .use_internal_ref_i(use_int),
    .analog_sample_i(sample), .frame_marker_o(frame_marker_o), .serial_result_o(serial_result_o),
    .serial_result_oe_o(serial_result_oe_o), .powered_up_o(powered_up_o), .track_mode_o(track_mode_o),
    .converting_o(converting_o), .result_o(result_o));
  sacs_serial_rx rx (.frame_marker_i(frame_marker_o), .data_i(data_line), .oe_i(serial_result_oe_o),
    .shift_clock_o(shift_clk), .word_o(rx_word), .bits_o(rx_bits));
  initial begin
    forever #10 clock_i = ~clock_i;
  end
  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [RES_W-1:0] seen, input logic [RES_W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask : cyc
  task automatic wait_conv(input logic v);
    n_wait = 0;
    while (converting_o !== v && n_wait < 3000) begin
      @(negedge clock_i);
      n_wait++;
    end
    chk(8'(n_wait < 3000), 8'h01);
  endtask : wait_conv
  // One conversion; e is the expected word, lo how long the pin stays low after the start
  task automatic conv(input logic [RES_W-1:0] s, input logic [RES_W-1:0] e, input int lo, input logic up_exp);
    int b;
    b = rx_bits;
    sample = s;
    cyc(1);
    trig_n = 1'b0;
    wait_conv(1'b1);
    n_start = n_wait;
    chk(8'(track_mode_o), 8'h00);
    cyc(lo);
    trig_n = 1'b1;
    wait_conv(1'b0);
    chk(8'(powered_up_o), 8'(up_exp));
    chk(result_o, e);
    for (int k = 0; k < 400 && rx_bits < b + 8; k++) cyc(1);
    chk(8'(rx_bits - b), 8'h08);
    chk(rx_word, e);
    // Ninth rise comes two cycles after the last sample; a tenth would be much later
    cyc(9);
    chk(8'(frame_marker_o), 8'h01);
    chk(8'(serial_result_oe_o), 8'h00);
    $display("test done: sample %h", s);
  endtask : conv
  initial begin
    cyc(16);
    chk(8'(frame_marker_o), 8'h01);
    chk(8'(serial_result_oe_o), 8'h00);
    chk(8'(powered_up_o), 8'h00);
    rst_n_i = 1'b1;
    trig_n = 1'b0;
    cyc(8);
    chk(8'(converting_o), 8'h00);
    trig_n = 1'b1;
    cyc(2);
    // Fall soon after wake: start waits for the external power-up count
    conv(8'h5a, 8'h5a, 40, 1'b0);
    chk(8'(n_start >= 34 && n_start <= 44), 8'h01);
    cyc(60);
    use_int = 1'b1;
    conv(8'hc3, 8'hc3, 40, 1'b0);
    chk(8'(n_start <= 8), 8'h01);
    cyc(30);
    chk(8'(powered_up_o), 8'h01);
    cyc(50); // Host lets the internal power-up pass
    // Back-to-back conversions that stay powered; each waits for the read to end
    foreach (rows[i]) conv(rows[i][15:8], rows[i][7:0], 5, 1'b1);
    chk(8'(n_start <= 8), 8'h01);
    // A trigger fall inside a frame closes it at once
    rx_mark = rx_bits;
    sample = 8'h96;
    trig_n = 1'b0;
    wait_conv(1'b1);
    cyc(5);
    trig_n = 1'b1;
    for (int k = 0; k < 400 && rx_bits < rx_mark + 3; k++) cyc(1);
    trig_n = 1'b0;
    cyc(6);
    chk(8'(frame_marker_o), 8'h01);
    chk(8'(serial_result_oe_o), 8'h00);
    trig_n = 1'b1;
    wait_conv(1'b0);
    $display("test done: reset, wake, rows and cut frame");
    end_of_test;
  end
  initial begin
    #200000;
    num_errors++;
    end_of_test;
  end
endmodule : tb_sacs_sequencer
